// ===== logic/ifb_flag_bank.sv
/*
 * interrupt flag status bank: two 16-bit flag words set by peripheral event
 * sources and read/written by software over AHB-Lite, plus a summary
 * status/enable/clear block driving one level interrupt.
 * assumes single whole-word transfers, one slave, request inputs synchronous
 * to hclk.
 */
`timescale 1ns/1ps
`default_nettype none
module ifb_flag_bank
	import ifb_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [1:0]       hresp,
	output logic [31:0]      hrdata,
	input  wire ifb_req_t    req,
	output ifb_flags_t       flags,
	output logic             irq
);

	typedef enum logic [1:0] {
		IFB_IDLE = 2'b01,
		IFB_DATA = 2'b10
	} ifb_phase_t;

	ifb_phase_t        phase_r;
	logic              wr_r;
	logic [11:0]       addr_r;
	logic [15:0]       three_r;
	logic [15:0]       four_r;
	logic [15:0]       set_three;
	logic [15:0]       set_four;
	logic [IFB_IRQ_W-1:0] sts_r;
	logic [IFB_IRQ_W-1:0] ena_r;
	logic [IFB_IRQ_W-1:0] sts_set;
	logic              take;
	logic              wr_three;
	logic              wr_four;
	logic              wr_ena;
	logic              wr_clr;
	logic [31:0]       rdata_nxt;

	// zero-wait slave: every transfer completes in its first data cycle
	assign hreadyout = 1'b1;
	assign hresp     = IFB_HRESP_OKAY;
	assign take      = clk_en && hsel && hready && (htrans == IFB_HTRANS_NONSEQ || htrans == IFB_HTRANS_SEQ);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_r <= IFB_IDLE;
			wr_r    <= 1'b0;
			addr_r  <= IFB_FLAGS_THREE_OFS;
		end else if (clk_en) begin
			phase_r <= take ? IFB_DATA : IFB_IDLE;
			wr_r    <= take && hwrite;
			addr_r  <= take ? haddr[11:0] : addr_r;
		end
	end

	assign wr_three = (phase_r == IFB_DATA) && wr_r && addr_r == IFB_FLAGS_THREE_OFS;
	assign wr_four  = (phase_r == IFB_DATA) && wr_r && addr_r == IFB_FLAGS_FOUR_OFS;
	assign wr_ena   = (phase_r == IFB_DATA) && wr_r && addr_r == IFB_IRQ_ENABLE_OFS;
	assign wr_clr   = (phase_r == IFB_DATA) && wr_r && addr_r == IFB_IRQ_CLEAR_OFS;

	// per-source set vectors, only at implemented positions
	always_comb begin
		set_three = IFB_FLAG_RST;
		set_four  = IFB_FLAG_RST;
		set_three[IFB_CAL_BIT]  = req.cal;
		set_three[IFB_DMA5_BIT] = req.dma5;
		set_three[IFB_EXT4_BIT] = req.ext4;
		set_three[IFB_EXT3_BIT] = req.ext3;
		set_three[IFB_BUSM_BIT] = req.busm;
		set_three[IFB_BUST_BIT] = req.bust;
		set_four[IFB_VDET_BIT]  = req.vdet;
		set_four[IFB_TOUCH_BIT] = req.touch;
		set_four[IFB_CRC_BIT]   = req.crc;
		set_four[IFB_SER2_BIT]  = req.ser2;
		set_four[IFB_SER1_BIT]  = req.ser1;
	end

	// a request in the same cycle as a software clear wins, so no event is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			three_r <= IFB_FLAG_RST;
			four_r  <= IFB_FLAG_RST;
		end else if (clk_en) begin
			if (wr_three)
				three_r <= (hwdata[15:0] | set_three) & IFB_THREE_MASK;
			else
				three_r <= three_r | set_three;
			if (wr_four)
				four_r <= (hwdata[15:0] | set_four) & IFB_FOUR_MASK;
			else
				four_r <= four_r | set_four;
		end
	end

	assign flags.three = three_r;
	assign flags.four  = four_r;

	// summary status: bit n goes up on any source request into flag word n (bit 0 third, bit 1 fourth)
	assign sts_set = {|set_four, |set_three};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sts_r <= IFB_IRQ_RST;
		end else if (clk_en) begin
			if (wr_clr)
				sts_r <= (sts_r & ~hwdata[IFB_IRQ_W-1:0]) | sts_set;
			else
				sts_r <= sts_r | sts_set;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ena_r <= IFB_IRQ_RST;
		else if (clk_en && wr_ena)
			ena_r <= hwdata[IFB_IRQ_W-1:0];
	end

	assign irq = |(sts_r & ena_r);

	// read data registered in the address phase so it stands in the data phase
	always_comb begin
		rdata_nxt = IFB_RDATA_RST;
		unique case (haddr[11:0])
			IFB_FLAGS_THREE_OFS: rdata_nxt[15:0] = three_r & IFB_THREE_MASK;
			IFB_FLAGS_FOUR_OFS:  rdata_nxt[15:0] = four_r & IFB_FOUR_MASK;
			IFB_IRQ_STATUS_OFS:  rdata_nxt[IFB_IRQ_W-1:0] = sts_r;
			IFB_IRQ_ENABLE_OFS:  rdata_nxt[IFB_IRQ_W-1:0] = ena_r;
			default:             rdata_nxt = IFB_RDATA_RST;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= IFB_RDATA_RST;
		else if (clk_en && take && !hwrite)
			hrdata <= rdata_nxt;
	end

	a_unimpl_three_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(three_r & ~IFB_THREE_MASK) == 16'h0000)
		else $error("unimplemented third-word bit set");

	a_unimpl_four_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(four_r & ~IFB_FOUR_MASK) == 16'h0000)
		else $error("unimplemented fourth-word bit set");

	a_cal_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.cal |=> three_r[IFB_CAL_BIT])
		else $error("calendar flag not set");

	a_dma5_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.dma5 |=> three_r[IFB_DMA5_BIT])
		else $error("dma5 flag not set");

	a_ext4_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.ext4 |=> three_r[IFB_EXT4_BIT])
		else $error("ext4 flag not set");

	a_ext3_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.ext3 |=> three_r[IFB_EXT3_BIT])
		else $error("ext3 flag not set");

	a_busm_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.busm |=> three_r[IFB_BUSM_BIT])
		else $error("bus master flag not set");

	a_bust_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.bust |=> three_r[IFB_BUST_BIT])
		else $error("bus target flag not set");

	a_vdet_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.vdet |=> four_r[IFB_VDET_BIT])
		else $error("voltage detect flag not set");

	a_touch_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.touch |=> four_r[IFB_TOUCH_BIT])
		else $error("touch flag not set");

	a_crc_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.crc |=> four_r[IFB_CRC_BIT])
		else $error("checksum flag not set");

	a_ser2_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.ser2 |=> four_r[IFB_SER2_BIT])
		else $error("serial two flag not set");

	a_ser1_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req.ser1 |=> four_r[IFB_SER1_BIT])
		else $error("serial one flag not set");

	a_flag_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_three && three_r[IFB_CAL_BIT] |=> three_r[IFB_CAL_BIT])
		else $error("flag lost");

	a_dma5_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_three && three_r[IFB_DMA5_BIT] |=> three_r[IFB_DMA5_BIT])
		else $error("dma5 flag lost");

	a_ext4_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_three && three_r[IFB_EXT4_BIT] |=> three_r[IFB_EXT4_BIT])
		else $error("ext4 flag lost");

	a_ext3_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_three && three_r[IFB_EXT3_BIT] |=> three_r[IFB_EXT3_BIT])
		else $error("ext3 flag lost");

	a_busm_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_three && three_r[IFB_BUSM_BIT] |=> three_r[IFB_BUSM_BIT])
		else $error("bus master flag lost");

	a_bust_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_three && three_r[IFB_BUST_BIT] |=> three_r[IFB_BUST_BIT])
		else $error("bus target flag lost");

	a_vdet_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_four && four_r[IFB_VDET_BIT] |=> four_r[IFB_VDET_BIT])
		else $error("voltage detect flag lost");

	a_touch_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_four && four_r[IFB_TOUCH_BIT] |=> four_r[IFB_TOUCH_BIT])
		else $error("touch flag lost");

	a_crc_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_four && four_r[IFB_CRC_BIT] |=> four_r[IFB_CRC_BIT])
		else $error("checksum flag lost");

	a_ser2_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_four && four_r[IFB_SER2_BIT] |=> four_r[IFB_SER2_BIT])
		else $error("serial two flag lost");

	a_ser1_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !wr_four && four_r[IFB_SER1_BIT] |=> four_r[IFB_SER1_BIT])
		else $error("serial one flag lost");

	a_zero_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_three && !hwdata[IFB_EXT3_BIT] && !req.ext3 |=> !three_r[IFB_EXT3_BIT])
		else $error("write zero did not clear");

	a_cal_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_three && !hwdata[IFB_CAL_BIT] && !req.cal |=> !three_r[IFB_CAL_BIT])
		else $error("calendar flag not cleared");

	a_dma5_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_three && !hwdata[IFB_DMA5_BIT] && !req.dma5 |=> !three_r[IFB_DMA5_BIT])
		else $error("dma5 flag not cleared");

	a_ext4_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_three && !hwdata[IFB_EXT4_BIT] && !req.ext4 |=> !three_r[IFB_EXT4_BIT])
		else $error("ext4 flag not cleared");

	a_busm_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_three && !hwdata[IFB_BUSM_BIT] && !req.busm |=> !three_r[IFB_BUSM_BIT])
		else $error("bus master flag not cleared");

	a_bust_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_three && !hwdata[IFB_BUST_BIT] && !req.bust |=> !three_r[IFB_BUST_BIT])
		else $error("bus target flag not cleared");

	a_vdet_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_four && !hwdata[IFB_VDET_BIT] && !req.vdet |=> !four_r[IFB_VDET_BIT])
		else $error("voltage detect flag not cleared");

	a_touch_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_four && !hwdata[IFB_TOUCH_BIT] && !req.touch |=> !four_r[IFB_TOUCH_BIT])
		else $error("touch flag not cleared");

	a_crc_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_four && !hwdata[IFB_CRC_BIT] && !req.crc |=> !four_r[IFB_CRC_BIT])
		else $error("checksum flag not cleared");

	a_ser2_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_four && !hwdata[IFB_SER2_BIT] && !req.ser2 |=> !four_r[IFB_SER2_BIT])
		else $error("serial two flag not cleared");

	a_ser1_clears: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_four && !hwdata[IFB_SER1_BIT] && !req.ser1 |=> !four_r[IFB_SER1_BIT])
		else $error("serial one flag not cleared");

	a_cal_write_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_three && hwdata[IFB_CAL_BIT] |=> three_r[IFB_CAL_BIT])
		else $error("write one did not set");

	// a low enable must freeze every register, flags and bus side alike
	a_enable_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
		!clk_en |=> $stable(three_r) && $stable(four_r) && $stable(sts_r) && $stable(ena_r) && $stable(hrdata))
		else $error("state moved while frozen");

	a_status_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && (|set_three) |=> sts_r[0])
		else $error("summary status not set");

	a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
		ena_r == IFB_IRQ_RST |-> !irq)
		else $error("interrupt without enable");

	a_ready_high: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && hresp == IFB_HRESP_OKAY)
		else $error("slave not ready or not okay");

	a_read_three_pad: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr[11:0] == IFB_FLAGS_THREE_OFS |=> (hrdata[15:0] & ~IFB_THREE_MASK) == 16'h0000)
		else $error("unimplemented third-word bit read as one");

	a_read_four_pad: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr[11:0] == IFB_FLAGS_FOUR_OFS |=> (hrdata[15:0] & ~IFB_FOUR_MASK) == 16'h0000)
		else $error("unimplemented fourth-word bit read as one");

endmodule
`default_nettype wire

// ===== logic/ifb_pkg.sv
/*
 * package for the interrupt flag status bank: register offsets, flag bit
 * positions, implemented-bit masks and the request and flag carrier types.
 * assumes an AHB-Lite slave with 32-bit data and word-aligned registers.
 */
`default_nettype none
package ifb_pkg;
	// register byte offsets
	localparam logic [11:0] IFB_FLAGS_THREE_OFS = 12'h000;
	localparam logic [11:0] IFB_FLAGS_FOUR_OFS  = 12'h004;
	localparam logic [11:0] IFB_IRQ_STATUS_OFS  = 12'h008;
	localparam logic [11:0] IFB_IRQ_ENABLE_OFS  = 12'h00c;
	localparam logic [11:0] IFB_IRQ_CLEAR_OFS   = 12'h010;

	localparam int IFB_FLAG_W = 16;

	// third flag word bit positions
	localparam int IFB_CAL_BIT   = 14;
	localparam int IFB_DMA5_BIT  = 13;
	localparam int IFB_EXT4_BIT  = 6;
	localparam int IFB_EXT3_BIT  = 5;
	localparam int IFB_BUSM_BIT  = 2;
	localparam int IFB_BUST_BIT  = 1;
	// fourth flag word bit positions
	localparam int IFB_TOUCH_BIT = 13;
	localparam int IFB_VDET_BIT  = 8;
	localparam int IFB_CRC_BIT   = 3;
	localparam int IFB_SER2_BIT  = 2;
	localparam int IFB_SER1_BIT  = 1;

	localparam logic [15:0] IFB_THREE_MASK = 16'h6066;
	localparam logic [15:0] IFB_FOUR_MASK  = 16'h210e;
	localparam logic [15:0] IFB_FLAG_RST   = 16'h0000;

	// summary interrupt status layout: one bit per flag word
	localparam int          IFB_IRQ_W      = 2;
	localparam logic [1:0]  IFB_IRQ_RST    = 2'h0;
	localparam logic [31:0] IFB_RDATA_RST  = 32'h0000_0000;

	localparam logic [1:0] IFB_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] IFB_HTRANS_SEQ    = 2'h3;
	localparam logic [1:0] IFB_HRESP_OKAY    = 2'h0;

	// peripheral request inputs, one pulse or level per source
	typedef struct packed {
		logic cal;
		logic dma5;
		logic ext4;
		logic ext3;
		logic busm;
		logic bust;
		logic touch;
		logic vdet;
		logic crc;
		logic ser2;
		logic ser1;
	} ifb_req_t;

	// latched flags fanned out to the vectoring logic
	typedef struct packed {
		logic [IFB_FLAG_W-1:0] three;
		logic [IFB_FLAG_W-1:0] four;
	} ifb_flags_t;
endpackage
`default_nettype wire

// ===== verification/ifb_event_src.sv
/*
 * peripheral event source model: raises one request pulse per fire strobe.
 * assumes fire and src_sel are driven just after a rising edge of hclk.
 */
`timescale 1ns/1ps
`default_nettype none
module ifb_event_src
	import ifb_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       fire,
	input  wire logic [3:0] src_sel,
	output ifb_req_t        req
);
	// a one-cycle pulse, so a later software clear is not undone by a held level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			req <= ifb_req_t'(11'h0);
		else
			req <= fire ? ifb_req_t'(11'h1 << src_sel) : ifb_req_t'(11'h0);
	end
endmodule
`default_nettype wire

// ===== verification/interrupt_flag_status_bank_tb.sv
/*
 * self-checking bench for the flag bank: AHB-Lite master tasks plus an
 * event source model. assumes the one slave answers with hreadyout.
 */
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_status_bank_tb;
	import ifb_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, irq, fire, clk_en;
	logic [1:0]  htrans, hresp;
	logic [2:0]  hsize;
	logic [3:0]  src_sel;
	logic [31:0] haddr, hwdata, hrdata, rd;
	ifb_req_t    req;
	int          err_count, checks;
	int          pos[11];
	ifb_flag_bank dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .req(req), .flags(), .irq(irq));
	ifb_event_src src_u (.hclk(hclk), .hresetn(hresetn), .fire(fire), .src_sel(src_sel), .req(req));
	initial begin
		hclk = 0;
		forever #5 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// address phase held until hready, then data phase held until hready
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1; htrans <= IFB_HTRANS_NONSEQ; hwrite <= w; haddr <= {20'h0, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0; hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk({30'h0, hresp}, {30'h0, IFB_HRESP_OKAY});
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic event_pulse(input int i);
		@(posedge hclk);
		src_sel <= 4'(i); fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
	endtask
	task automatic end_sim;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		end_sim;
	end
	initial begin
		pos = '{IFB_SER1_BIT, IFB_SER2_BIT, IFB_CRC_BIT, IFB_VDET_BIT, IFB_TOUCH_BIT, IFB_BUST_BIT,
			IFB_BUSM_BIT, IFB_EXT3_BIT, IFB_EXT4_BIT, IFB_DMA5_BIT, IFB_CAL_BIT};
		{hsel, hwrite, fire, err_count, checks} = '0;
		htrans = 2'h0; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0; src_sel = 4'h0;
		clk_en = 1'b1;
		hresetn = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(IFB_FLAGS_THREE_OFS, 32'h0);
		rchk(IFB_FLAGS_FOUR_OFS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test reset done");
		bus(1'b1, IFB_FLAGS_THREE_OFS, 32'hffff_ffff);
		rchk(IFB_FLAGS_THREE_OFS, {16'h0, IFB_THREE_MASK});
		bus(1'b1, IFB_FLAGS_FOUR_OFS, 32'hffff_ffff);
		rchk(IFB_FLAGS_FOUR_OFS, {16'h0, IFB_FOUR_MASK});
		bus(1'b1, IFB_FLAGS_THREE_OFS, 32'h0);
		bus(1'b1, IFB_FLAGS_FOUR_OFS, 32'h0);
		rchk(IFB_FLAGS_THREE_OFS, 32'h0);
		rchk(IFB_FLAGS_FOUR_OFS, 32'h0);
		$display("test masks done");
		// each source alone, so a flag landing in the wrong position is seen
		for (int i = 0; i < 11; i++) begin
			event_pulse(i);
			rchk(i < 5 ? IFB_FLAGS_FOUR_OFS : IFB_FLAGS_THREE_OFS, 32'h1 << pos[i]);
			bus(1'b1, i < 5 ? IFB_FLAGS_FOUR_OFS : IFB_FLAGS_THREE_OFS, 32'h0);
			rchk(i < 5 ? IFB_FLAGS_FOUR_OFS : IFB_FLAGS_THREE_OFS, 32'h0);
		end
		$display("test sources done");
		// a request arriving while the enable is low must be dropped
		clk_en <= 1'b0;
		event_pulse(10);
		@(posedge hclk);
		clk_en <= 1'b1;
		rchk(IFB_FLAGS_THREE_OFS, 32'h0);
		$display("test freeze done");
		rchk(IFB_IRQ_STATUS_OFS, 32'h3);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, IFB_IRQ_ENABLE_OFS, 32'h2);
		@(negedge hclk);
		chk({31'h0, irq}, 32'h1);
		rchk(IFB_IRQ_ENABLE_OFS, 32'h2);
		bus(1'b1, IFB_IRQ_CLEAR_OFS, 32'h3);
		@(negedge hclk);
		chk({31'h0, irq}, 32'h0);
		rchk(IFB_IRQ_STATUS_OFS, 32'h0);
		rchk(IFB_IRQ_CLEAR_OFS, 32'h0);
		bus(1'b1, 12'h020, 32'hffff_ffff);
		rchk(12'h020, 32'h0);
		$display("test interrupt done");
		end_sim;
	end
endmodule
`default_nettype wire
